// ---- hw/lpmc_pkg.sv ----
// Package for the low power mode controller.
// Assumes one 125 MHz system clock domain; all constants live here.
package lpmc_pkg;
  // Number of edge event lines
  localparam int LPMC_LINES = 27;
  // Line positions of the fixed wakeup sources
  localparam int LPMC_LINE_SUPPLY = 16;
  localparam int LPMC_LINE_ALARM = 17;
  // Regulator mode encodings
  localparam logic [1:0] LPMC_REG_MAIN = 2'h0;
  localparam logic [1:0] LPMC_REG_LOWP = 2'h1;
  localparam logic [1:0] LPMC_REG_OFF = 2'h2;
  // Low power request encodings
  localparam logic [1:0] LPMC_REQ_SLEEP = 2'h1;
  localparam logic [1:0] LPMC_REQ_STOP = 2'h2;
  localparam logic [1:0] LPMC_REQ_STBY = 2'h3;
  // Clock restart settle time after Stop
  localparam int LPMC_RESTART_NS = 64;
  localparam int LPMC_CLK_NS = 8;
  localparam int LPMC_RESTART_CYC = (LPMC_RESTART_NS + LPMC_CLK_NS - 1) / LPMC_CLK_NS;
  localparam logic [3:0] LPMC_RESTART_CNT = 4'(LPMC_RESTART_CYC);
  // Power mode states, one-hot
  typedef enum logic [4:0] {
    LPMC_RUN = 5'h01,
    LPMC_SLEEP = 5'h02,
    LPMC_STOP = 5'h04,
    LPMC_WAKE = 5'h08,
    LPMC_STBY = 5'h10
  } lpmc_state_e;
endpackage : lpmc_pkg

// ---- hw/lpmc_edge_lines.sv ----
// Edge event lines: sync, edge detect, per-line mask and trigger select.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/1ps
module lpmc_edge_lines #(
  parameter int N = lpmc_pkg::LPMC_LINES // Line count
) (
  input wire logic clk_sys, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [N-1:0] line_in, // Raw event lines
  input wire logic [N-1:0] rise_en, // Trigger on rising edge
  input wire logic [N-1:0] fall_en, // Trigger on falling edge
  input wire logic [N-1:0] unmask, // Line enable
  output logic [N-1:0] hit // One-cycle event pulse per line
);
  import lpmc_pkg::*;
  ////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [N-1:0] s1; // First sync stage
    logic [N-1:0] s2; // Second sync stage
    logic [N-1:0] prev; // Last synced level
    logic [2:0] ready; // Fill marks since reset
    logic [N-1:0] hit; // Registered event
  } lpmc_edge_s;
  lpmc_edge_s st, next_st;
  // Edge detection on synced levels only
  always_comb begin
    next_st = st;
    next_st.s1 = line_in;
    next_st.s2 = st.s1;
    next_st.prev = st.s2;
    // Pipeline fill; prev is stale for three edges after reset
    next_st.ready = {st.ready[1:0], 1'b1};
    // Per-line trigger and mask
    // Held off until prev is real, else a line idling high fakes an edge
    next_st.hit = {N{st.ready[2]}} & unmask &
      ((rise_en & st.s2 & ~st.prev) | (fall_en & ~st.s2 & st.prev));
  end
  // State register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign hit = st.hit;
  // Assertions
  property p_rise;
    @(posedge clk_sys) disable iff (!arst_n)
    (st.ready[2] && st.s2[0] && !st.prev[0] && rise_en[0] && unmask[0]) |=> hit[0];
  endproperty
  a_rise: assert property (p_rise) else $error("rise edge missed");
  property p_mask;
    @(posedge clk_sys) disable iff (!arst_n)
    !$past(unmask[0]) |-> !hit[0];
  endproperty
  a_mask: assert property (p_mask) else $error("masked line fired");
  c_hit: cover property (@(posedge clk_sys) disable iff (!arst_n) |hit);
endmodule : lpmc_edge_lines

// ---- hw/lpmc_top.sv ----
// Low power mode controller: Run, Sleep, Stop, Standby sequencing,
// regulator mode, clock gating, supply supervision and wakeup sources.
// Assumes supply comparator outputs and wakeup sources are async pins.
//
// Contract
// - Hold reset while supply below threshold
// - Option bit disables analog supply supervision
// - Supply detector interrupt on fall, rise, both
// - Regulator main, low power, power down
// - Regulator enabled after reset, off in Standby
// - Sleep halts only processor clock
// - Stop gates core clocks, PLL, oscillators
// - Software picks Stop regulator mode
// - Any unmasked edge event line wakes Stop
// - Standby powers off core domain
// - Standby exits on reset, watchdog, pin, alarm
// - RTC and watchdog keep running always
// - 27 lines, edge select, individual mask
`timescale 1ns/1ps
module lpmc_top #(
  parameter int N = lpmc_pkg::LPMC_LINES // Edge event line count
) (
  input wire logic clk_sys, // System clock 125 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic main_supply_ok, // Main supply above reset threshold
  input wire logic analog_supply_ok, // Analog supply above reset threshold
  input wire logic analog_supervise_off, // Option bit: ignore analog supply
  input wire logic external_reset_pin_n, // External reset pin, active low
  input wire logic independent_watchdog_rst, // Watchdog reset request
  input wire logic wakeup_pin, // Standby wakeup pin
  input wire logic rtc_alarm, // RTC alarm level
  input wire logic supply_below, // Supply detector: below threshold
  input wire logic supply_detect_en, // Supply detector enable
  input wire logic supply_irq_fall, // Interrupt on falling below
  input wire logic supply_irq_rise, // Interrupt on rising above
  input wire logic [N-1:0] edge_event_lines, // Raw event lines
  input wire logic [N-1:0] edge_rise_en, // Rising trigger select
  input wire logic [N-1:0] edge_fall_en, // Falling trigger select
  input wire logic [N-1:0] edge_unmask, // Per-line enable
  input wire logic [1:0] mode_req, // Low power request from core
  input wire logic mode_req_valid, // Request strobe, one cycle
  input wire logic stop_reg_lowp, // Use low power regulator in Stop
  input wire logic core_irq, // Any pending interrupt or event
  output logic chip_reset_n, // Chip reset, active low
  output logic supply_irq, // Supply detector interrupt pulse
  output logic [N-1:0] edge_event, // Edge line event pulses
  output logic [1:0] regulator_mode, // Regulator mode
  output logic regulator_en, // Regulator enable
  output logic cpu_clk_en, // Processor clock enable
  output logic core_clk_en, // Core domain clocks enable
  output logic pll_en, // PLL enable
  output logic internal_fast_oscillator_en, // Internal fast osc enable
  output logic external_fast_oscillator_en, // External fast osc enable
  output logic core_power_en, // Core domain power enable
  output logic rtc_wdg_clk_en, // RTC and watchdog clocks enable
  output logic [4:0] power_state // Current one-hot power state
);
  import lpmc_pkg::*;
  ////////////////////////////////////////////////////////////////
  // Whole state in one struct
  typedef struct packed {
    logic [6:0] s1; // First sync stage of pins
    logic [6:0] s2; // Second sync stage of pins
    logic wk_prev; // Last synced wakeup pin
    logic below_prev; // Last synced detector level
    logic supply_irq; // Interrupt pulse
    logic rst_n; // Chip reset out
    lpmc_state_e state; // Power state
    logic [3:0] cnt; // Restart settle counter
  } lpmc_top_s;
  lpmc_top_s st, next_st;
  logic [N-1:0] hits; // Edge detector events
  // Synced pin aliases
  logic m_ok, a_ok, ext_n, wdg, wk, alarm, below;
  assign {m_ok, a_ok, ext_n, wdg, wk, alarm, below} = st.s2;
  ////////////////////////////////////////////////////////////////
  // Edge event lines
  lpmc_edge_lines #(.N(N)) u_lines (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .line_in(edge_event_lines),
    .rise_en(edge_rise_en),
    .fall_en(edge_fall_en),
    .unmask(edge_unmask),
    .hit(hits)
  );
  assign edge_event = hits;
  ////////////////////////////////////////////////////////////////
  // Next state
  logic supply_ok; // Supervised supply good
  logic stby_exit; // Any Standby wakeup source
  always_comb begin
    next_st = st;
    next_st.s1 = {main_supply_ok, analog_supply_ok, external_reset_pin_n,
                  independent_watchdog_rst, wakeup_pin, rtc_alarm, supply_below};
    next_st.s2 = st.s1;
    next_st.wk_prev = wk;
    next_st.below_prev = below;
    supply_ok = m_ok && (a_ok || analog_supervise_off);
    next_st.rst_n = supply_ok && ext_n && !wdg;
    // Detector interrupt on selected edges
    // Held off while chip reset is low: below_prev is stale after reset
    next_st.supply_irq = st.rst_n && supply_detect_en &&
      ((supply_irq_fall && below && !st.below_prev) ||
       (supply_irq_rise && !below && st.below_prev));
    stby_exit = !ext_n || wdg || (wk && !st.wk_prev) || alarm;
    if (!st.rst_n) begin
      // Reset returns to Run
      next_st.state = LPMC_RUN;
      next_st.cnt = '0;
    end else begin
      case (st.state)
        LPMC_RUN: begin
          if (mode_req_valid && mode_req == LPMC_REQ_SLEEP) begin
            next_st.state = LPMC_SLEEP;
          end else if (mode_req_valid && mode_req == LPMC_REQ_STOP) begin
            next_st.state = LPMC_STOP;
          end else if (mode_req_valid && mode_req == LPMC_REQ_STBY) begin
            next_st.state = LPMC_STBY;
          end
        end
        LPMC_SLEEP: begin
          if (core_irq || (|hits)) begin
            next_st.state = LPMC_RUN;
          end
        end
        LPMC_STOP: begin
          if (|hits) begin
            next_st.state = LPMC_WAKE;
            next_st.cnt = LPMC_RESTART_CNT;
          end
        end
        LPMC_WAKE: begin
          if (st.cnt <= 4'h1) begin
            next_st.state = LPMC_RUN;
            next_st.cnt = '0;
          end else begin
            next_st.cnt = st.cnt - 4'h1;
          end
        end
        LPMC_STBY: begin
          // Wake from Standby acts as a reset of the core
          if (stby_exit) begin
            next_st.state = LPMC_RUN;
          end
        end
        default: begin
          next_st.state = LPMC_RUN;
        end
      endcase
    end
  end
  // State register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{s1: '0, s2: '0, wk_prev: 1'b0, below_prev: 1'b0, supply_irq: 1'b0,
              rst_n: 1'b0, state: LPMC_RUN, cnt: '0};
    end else begin
      st <= next_st;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Outputs from state
  logic in_stop, in_stby, in_run_like;
  assign in_stop = (st.state == LPMC_STOP);
  assign in_stby = (st.state == LPMC_STBY);
  assign in_run_like = !in_stop && !in_stby;
  assign chip_reset_n = st.rst_n;
  assign supply_irq = st.supply_irq;
  assign power_state = st.state;
  assign regulator_mode = in_stby ? LPMC_REG_OFF :
                          (in_stop && stop_reg_lowp) ? LPMC_REG_LOWP : LPMC_REG_MAIN;
  assign regulator_en = !in_stby;
  // Processor clock halted in Sleep, Stop, Standby, settle
  assign cpu_clk_en = (st.state == LPMC_RUN) && st.rst_n;
  assign core_clk_en = in_run_like;
  assign pll_en = in_run_like;
  assign internal_fast_oscillator_en = in_run_like;
  assign external_fast_oscillator_en = in_run_like;
  assign core_power_en = !in_stby;
  assign rtc_wdg_clk_en = 1'b1;
  ////////////////////////////////////////////////////////////////
  // Assertions
  property p_reset_hold;
    @(posedge clk_sys) disable iff (!arst_n)
    !$past(m_ok) |-> !chip_reset_n;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset released on low supply");
  property p_analog_opt;
    @(posedge clk_sys) disable iff (!arst_n)
    ($past(m_ok) && $past(ext_n) && !$past(wdg) && $past(analog_supervise_off)) |-> chip_reset_n;
  endproperty
  a_analog_opt: assert property (p_analog_opt) else $error("analog bypass ignored");
  property p_pvd_fall;
    @(posedge clk_sys) disable iff (!arst_n)
    (st.rst_n && supply_detect_en && supply_irq_fall && below && !st.below_prev) |=>
      supply_irq;
  endproperty
  a_pvd_fall: assert property (p_pvd_fall) else $error("detector fall missed");
  property p_reg_stby;
    @(posedge clk_sys) disable iff (!arst_n)
    in_stby |-> (regulator_mode == LPMC_REG_OFF && !regulator_en && !core_power_en);
  endproperty
  a_reg_stby: assert property (p_reg_stby) else $error("regulator on in standby");
  property p_stop_lp;
    @(posedge clk_sys) disable iff (!arst_n)
    (in_stop && stop_reg_lowp) |-> regulator_mode == LPMC_REG_LOWP;
  endproperty
  a_stop_lp: assert property (p_stop_lp) else $error("stop regulator mode wrong");
  property p_sleep;
    @(posedge clk_sys) disable iff (!arst_n)
    (st.state == LPMC_SLEEP) |-> (!cpu_clk_en && core_clk_en && pll_en);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep clock gating wrong");
  property p_stop_clk;
    @(posedge clk_sys) disable iff (!arst_n)
    in_stop |-> (!core_clk_en && !pll_en && !internal_fast_oscillator_en);
  endproperty
  a_stop_clk: assert property (p_stop_clk) else $error("clocks run in stop");
  property p_stop_wake;
    @(posedge clk_sys) disable iff (!arst_n)
    (in_stop && (|hits) && st.rst_n) |=> (st.state == LPMC_WAKE) ##[1:8] cpu_clk_en;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop wake failed");
  property p_wake_order;
    @(posedge clk_sys) disable iff (!arst_n)
    (st.state == LPMC_WAKE) |-> (core_clk_en && regulator_mode == LPMC_REG_MAIN && !cpu_clk_en);
  endproperty
  a_wake_order: assert property (p_wake_order) else $error("cpu before restart");
  property p_stby_exit;
    @(posedge clk_sys) disable iff (!arst_n)
    (in_stby && alarm && st.rst_n) |=> st.state == LPMC_RUN;
  endproperty
  a_stby_exit: assert property (p_stby_exit) else $error("standby alarm missed");
  property p_aon;
    @(posedge clk_sys) disable iff (!arst_n)
    (in_stop || in_stby) |-> rtc_wdg_clk_en;
  endproperty
  a_aon: assert property (p_aon) else $error("always-on clocks stopped");
  c_sleep: cover property (@(posedge clk_sys) disable iff (!arst_n) st.state == LPMC_SLEEP);
  c_wake: cover property (@(posedge clk_sys) disable iff (!arst_n) st.state == LPMC_WAKE);
  c_stby: cover property (@(posedge clk_sys) disable iff (!arst_n) in_stby ##1 !in_stby);
endmodule : lpmc_top

// ---- bench/lpmc_core_model.sv ----
// Processor core model: issues low power requests to the controller.
// Assumes requests are only made while the controller is in Run.
`timescale 1ns/1ps
module lpmc_core_model (
  input wire logic clk_sys, // System clock
  output logic [1:0] mode_req, // Low power request code
  output logic mode_req_valid // One-cycle request strobe
);
  // Idle: strobe low, code not meaningful
  initial begin
    mode_req = 2'h0;
    mode_req_valid = 1'b0;
  end
  // One request after a lag, slow cores use a long lag
  task automatic request(input logic [1:0] kind, input int lag);
    repeat (lag) @(negedge clk_sys);
    mode_req <= kind;
    mode_req_valid <= 1'b1;
    @(negedge clk_sys);
    mode_req_valid <= 1'b0;
    // Released code shows garbage, not the last value
    mode_req <= ~kind;
  endtask : request
endmodule : lpmc_core_model

// ---- bench/lpmc_top_tb.sv ----
// Testbench for the low power mode controller.
// Assumes lpmc_core_model as the core; inputs move on falling edges.
`timescale 1ns/1ps
module lpmc_top_tb;
  import lpmc_pkg::*;
  logic clk_sys, arst_n, main_ok, ana_ok, ana_off, ext_n, wdg, wk_pin, alarm;
  logic below, det_en, irq_f, irq_r, stop_lowp, core_irq, req_vld, rst_n, sup_irq;
  logic reg_en, cpu_en, core_en, pll_en, ifo_en, efo_en, pwr_en, rtc_en;
  logic [LPMC_LINES-1:0] lines, rise_en, fall_en, unmask, edge_event;
  logic [1:0] mode_req, reg_mode;
  logic [4:0] state;
  int fail_count, checked, ev_cnt, irq_cnt;
  ////////////////////////////////////////////////////////////////////////
  lpmc_core_model core (.clk_sys(clk_sys), .mode_req(mode_req), .mode_req_valid(req_vld));
  lpmc_top DUT (.clk_sys(clk_sys), .arst_n(arst_n), .main_supply_ok(main_ok),
    .analog_supply_ok(ana_ok), .analog_supervise_off(ana_off),
    .external_reset_pin_n(ext_n), .independent_watchdog_rst(wdg), .wakeup_pin(wk_pin),
    .rtc_alarm(alarm), .supply_below(below), .supply_detect_en(det_en),
    .supply_irq_fall(irq_f), .supply_irq_rise(irq_r), .edge_event_lines(lines),
    .edge_rise_en(rise_en), .edge_fall_en(fall_en), .edge_unmask(unmask),
    .mode_req(mode_req), .mode_req_valid(req_vld), .stop_reg_lowp(stop_lowp),
    .core_irq(core_irq), .chip_reset_n(rst_n), .supply_irq(sup_irq),
    .edge_event(edge_event), .regulator_mode(reg_mode), .regulator_en(reg_en),
    .cpu_clk_en(cpu_en), .core_clk_en(core_en), .pll_en(pll_en),
    .internal_fast_oscillator_en(ifo_en), .external_fast_oscillator_en(efo_en),
    .core_power_en(pwr_en), .rtc_wdg_clk_en(rtc_en), .power_state(state));
  ////////////////////////////////////////////////////////////////////////
  // 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Pulse counters, one count per high cycle; an unknown counts as a pulse
  always @(posedge clk_sys) begin
    ev_cnt += int'(edge_event !== '0);
    irq_cnt += int'(sup_irq !== 1'b0);
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  // Selects state (0) or chip reset (1) for bounded waits
  function automatic logic [4:0] probe(input int sel);
    if (sel == 1)
      return {4'h0, rst_n};
    return state;
  endfunction : probe
  // Bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_for(input int sel, input logic [4:0] want);
    int n = 0;
    while (probe(sel) !== want && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    // Still no match: a late arrival must not end the run as a pass
    if (probe(sel) !== want) begin
      check("wait", probe(sel), want);
      end_sim();
    end
  endtask : wait_for
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    repeat (20) @(negedge clk_sys);
    check("reset held", rst_n, 1'b0);
    check("reg enabled", {reg_en, reg_mode}, {1'b1, LPMC_REG_MAIN});
    arst_n = 1'b1;
    wait_for(1, 5'h01);
  endtask : t_reset
  task automatic t_supply;
    main_ok = 1'b0;
    wait_for(1, 5'h00);
    repeat (10) @(negedge clk_sys);
    check("reset while low", rst_n, 1'b0);
    main_ok = 1'b1;
    wait_for(1, 5'h01);
    ana_off = 1'b1;
    ana_ok = 1'b0;
    repeat (10) @(negedge clk_sys);
    check("analog ignored", rst_n, 1'b1);
    ana_off = 1'b0;
    wait_for(1, 5'h00);
    ana_ok = 1'b1;
    wait_for(1, 5'h01);
  endtask : t_supply
  task automatic t_sleep;
    core.request(2'h0, 0);
    repeat (3) @(negedge clk_sys);
    check("null request", {state, reg_mode}, {LPMC_RUN, LPMC_REG_MAIN});
    core.request(LPMC_REQ_SLEEP, 3);
    wait_for(0, LPMC_SLEEP);
    check("sleep cpu", cpu_en, 1'b0);
    check("sleep rest", {core_en, pll_en, ifo_en, efo_en, reg_mode}, 6'h3C);
    core_irq = 1'b1;
    wait_for(0, LPMC_RUN);
    core_irq = 1'b0;
    check("sleep exit", cpu_en, 1'b1);
  endtask : t_sleep
  task automatic t_stop(input logic lowp, input int k);
    stop_lowp = lowp;
    core.request(LPMC_REQ_STOP, 0);
    wait_for(0, LPMC_STOP);
    check("stop clocks", {cpu_en, core_en, pll_en, ifo_en, efo_en}, 5'h00);
    check("stop reg", reg_mode, lowp ? LPMC_REG_LOWP : LPMC_REG_MAIN);
    check("stop keep", {rtc_en, reg_en, pwr_en}, 3'h7);
    lines[k] = ~lines[k];
    wait_for(0, LPMC_WAKE);
    check("wake order", {reg_mode, core_en, cpu_en}, {LPMC_REG_MAIN, 2'b10});
    wait_for(0, LPMC_RUN);
    check("wake cpu", cpu_en, 1'b1);
  endtask : t_stop
  // Toggle one line and count event pulses
  task automatic hit(input int k, input int n);
    ev_cnt = 0;
    lines[k] = ~lines[k];
    repeat (8) @(negedge clk_sys);
    check("edge events", ev_cnt, n);
  endtask : hit
  task automatic t_edges;
    rise_en[5] = 1'b0;
    unmask[6] = 1'b0;
    hit(5, 0);
    hit(5, 1);
    hit(6, 0);
    hit(26, 1);
    hit(26, 1);
    rise_en[5] = 1'b1;
    unmask[6] = 1'b1;
  endtask : t_edges
  task automatic t_standby(input int src);
    core.request(LPMC_REQ_STBY, 1);
    wait_for(0, LPMC_STBY);
    check("stby reg", {reg_mode, reg_en}, {LPMC_REG_OFF, 1'b0});
    check("stby power", {pwr_en, core_en, pll_en, ifo_en, efo_en}, 5'h00);
    check("stby rtc", rtc_en, 1'b1);
    case (src)
      0: wk_pin = 1'b1;
      1: alarm = 1'b1;
      2: wdg = 1'b1;
      default: ext_n = 1'b0;
    endcase
    wait_for(0, LPMC_RUN);
    if (src > 1)
      wait_for(1, 5'h00);
    {wk_pin, alarm, wdg, ext_n} = 4'h1;
    wait_for(1, 5'h01);
  endtask : t_standby
  // Move the detector output and count interrupt pulses
  task automatic irq_step(input logic v, input int n);
    irq_cnt = 0;
    below = v;
    repeat (10) @(negedge clk_sys);
    check("supply irq", irq_cnt, n);
  endtask : irq_step
  task automatic t_irq;
    {det_en, irq_f, irq_r} = 3'h6;
    irq_step(1'b1, 1);
    irq_step(1'b0, 0);
    {irq_f, irq_r} = 2'h1;
    irq_step(1'b1, 0);
    irq_step(1'b0, 1);
    {irq_f, irq_r} = 2'h3;
    irq_step(1'b1, 1);
    irq_step(1'b0, 1);
    {det_en, irq_f} = 2'h1;
    irq_step(1'b1, 0);
  endtask : t_irq
  // Async reset in mid-run from Standby; lines 0, 6, 26 and the detector idle high
  task automatic t_rearm;
    core.request(LPMC_REQ_STBY, 1);
    wait_for(0, LPMC_STBY);
    det_en = 1'b1;
    arst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("rearm state", {state, rst_n}, {LPMC_RUN, 1'b0});
    check("rearm reg", {reg_en, reg_mode, pwr_en}, {1'b1, LPMC_REG_MAIN, 1'b1});
    ev_cnt = 0;
    irq_cnt = 0;
    arst_n = 1'b1;
    wait_for(1, 5'h01);
    repeat (4) @(negedge clk_sys);
    check("no false edge", ev_cnt, 0);
    check("no false irq", irq_cnt, 0);
  endtask : t_rearm
  ////////////////////////////////////////////////////////////////////////
  initial begin
    fail_count = 0;
    checked = 0;
    {arst_n, main_ok, ana_ok, ana_off, ext_n, wdg, wk_pin, alarm} = 8'h68;
    {below, det_en, irq_f, irq_r, stop_lowp, core_irq} = 6'h00;
    {lines, unmask} = {{LPMC_LINES{1'b0}}, {LPMC_LINES{1'b1}}};
    {rise_en, fall_en} = '1;
    t_reset();
    t_supply();
    t_sleep();
    t_stop(1'b1, 26);
    t_stop(1'b0, 0);
    t_edges();
    for (int s = 0; s < 4; s++) begin
      t_standby(s);
    end
    t_irq();
    t_rearm();
    end_sim();
  end
endmodule : lpmc_top_tb
